/* rtl/tci_div_rom.v */
// divider selection table, registered read
`timescale 1ns/100ps
`include "tci_map.vh"

module tci_div_rom (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [5:0]  addr,
  output reg  [27:0] data_q
);

  // ****************************************************************
  // dtmf group ratios and keypad pairing
  // ****************************************************************
  function [12:0] lo_ratio;
    input [1:0] i;
    begin
      case (i)
        2'h0: lo_ratio = 13'h1409;
        2'h1: lo_ratio = 13'h1226;
        2'h2: lo_ratio = 13'h1071;
        default: lo_ratio = 13'h0ED3;
      endcase
    end
  endfunction

  function [12:0] hi_ratio;
    input [1:0] i;
    begin
      case (i)
        2'h0: hi_ratio = 13'h0B97;
        2'h1: hi_ratio = 13'h0A6C;
        2'h2: hi_ratio = 13'h096F;
        default: hi_ratio = 13'h0889;
      endcase
    end
  endfunction

  // {row, column} of each key code
  function [3:0] key_pair;
    input [3:0] k;
    begin
      case (k)
        4'h0: key_pair = 4'hD;
        4'h1: key_pair = 4'h0;
        4'h2: key_pair = 4'h1;
        4'h3: key_pair = 4'h2;
        4'h4: key_pair = 4'h4;
        4'h5: key_pair = 4'h5;
        4'h6: key_pair = 4'h6;
        4'h7: key_pair = 4'h8;
        4'h8: key_pair = 4'h9;
        4'h9: key_pair = 4'hA;
        4'hA: key_pair = 4'h3;
        4'hB: key_pair = 4'h7;
        4'hC: key_pair = 4'hB;
        4'hD: key_pair = 4'hF;
        4'hE: key_pair = 4'hC;
        default: key_pair = 4'hE;
      endcase
    end
  endfunction

  reg [1:0]  kind;
  reg [12:0] ra;
  reg [12:0] rb;
  reg [3:0]  kp;

  always @* begin
    kind = `TCI_KIND_SINGLE;
    ra   = 13'h0000;
    rb   = 13'h0000;
    kp   = key_pair(addr[3:0]);
    case (addr)
      6'h00, 6'h20: kind = `TCI_KIND_MUTE;
      6'h01, 6'h02, 6'h03,
      6'h21, 6'h22, 6'h23: kind = `TCI_KIND_STBY;
      6'h04: ra = 13'h0775;
      6'h05: ra = 13'h0719;
      6'h06: ra = 13'h05EE;
      6'h07: ra = 13'h05A9;
      6'h08, 6'h09, 6'h0A, 6'h0B: ra = lo_ratio(addr[1:0]);
      6'h0C, 6'h0D, 6'h0E, 6'h0F: ra = hi_ratio(addr[1:0]);
      6'h24: ra = 13'h0AC8;
      6'h25: ra = 13'h06A6;
      6'h26: ra = 13'h0BAE;
      6'h27: ra = 13'h0661;
      6'h28: ra = 13'h0E49;
      6'h29: ra = 13'h0BDC;
      6'h2A: ra = 13'h0D07;
      6'h2B: ra = 13'h0B0D;
      6'h2C: ra = 13'h0872;
      6'h2D: ra = 13'h078C;
      6'h2E: ra = 13'h06EB;
      6'h2F: ra = 13'h064A;
      6'h30: ra = 13'h1676;
      6'h31: ra = 13'h1534;
      6'h32: ra = 13'h1409;
      6'h33: ra = 13'h12DE;
      6'h34: ra = 13'h11E1;
      6'h35: ra = 13'h10CD;
      6'h36: ra = 13'h0FE7;
      6'h37: ra = 13'h0F01;
      6'h38: ra = 13'h0E32;
      6'h39: ra = 13'h0D63;
      6'h3A: ra = 13'h0C94;
      6'h3B: ra = 13'h0B3B;
      6'h3C: ra = 13'h0A9A;
      6'h3D: ra = 13'h09F9;
      6'h3E: ra = 13'h08E5;
      6'h3F: ra = 13'h07E8;
      default: begin
        kind = `TCI_KIND_DUAL;
        ra   = lo_ratio(kp[3:2]);
        rb   = hi_ratio(kp[1:0]);
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      data_q <= {`TCI_KIND_STBY, 26'h000_0000};
    end else begin
      data_q <= {kind, ra, rb};
    end
  end

endmodule // tci_div_rom

/* rtl/tci_freq_div.v */
// frequency divider: square wave of one period per ratio timebase ticks
`timescale 1ns/100ps

module tci_freq_div #(
  parameter W = 13
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         tick,
  input  wire [W-1:0] ratio,
  output reg          sq_q
);

  reg [W-1:0] cnt_q;
  reg [W-1:0] ratio_q;

  // restart the period whenever a new ratio arrives
  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_q   <= {W{1'b0}};
      ratio_q <= {W{1'b0}};
      sq_q    <= 1'b0;
    end else begin
      ratio_q <= ratio;
      if (ratio == {W{1'b0}} || ratio != ratio_q) begin
        cnt_q <= {W{1'b0}};
        sq_q  <= 1'b0;
      end else if (tick) begin
        if (cnt_q >= ratio - {{(W-1){1'b0}}, 1'b1}) begin
          cnt_q <= {W{1'b0}};
        end else begin
          cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
        sq_q <= (cnt_q < (ratio >> 1));
      end
    end
  end

endmodule // tci_freq_div

/* rtl/tci_map.vh */
// constants shared by the tone code input control design
`ifndef TCI_MAP_VH
`define TCI_MAP_VH

// ****************************************************************
// apb register map
// ****************************************************************
`define TCI_PADDR_W      8
`define TCI_REG_STATUS   8'h00
`define TCI_REG_CODE     8'h04

// status register fields
`define TCI_ST_CODE_LSB  0
`define TCI_ST_KIND_LSB  6
`define TCI_ST_OSC_BIT   8
`define TCI_ST_PAR_BIT   9
`define TCI_ST_BUSY_BIT  10
`define TCI_ST_SEL_BIT   11

// ****************************************************************
// code table
// ****************************************************************
`define TCI_CODE_RESET   6'h01
`define TCI_KIND_MUTE    2'h0
`define TCI_KIND_SINGLE  2'h1
`define TCI_KIND_DUAL    2'h2
`define TCI_KIND_STBY    2'h3
`define TCI_RATIO_W      13

// ****************************************************************
// serial slave
// ****************************************************************
`define TCI_SLAVE_HI6    6'h24

// ****************************************************************
// timebase
// ****************************************************************
`define TCI_CLK_HZ       28'h5F5_E100
`define TCI_OSC_HZ       28'h036_9E99

`endif

/* rtl/tci_tone_ctrl.v */
// tone code input control: parallel and serial code entry, decode, dividers
//
// Function
// - mode pin high takes parallel codes; low or open takes serial codes.
// - upper two code bits choose single, dual, modem or musical application.
// - lower four bits pick the tone; with application bits also standby.
// - parallel code captured on strobe falling edge, then tone presented.
// - selection held until next strobe falling edge brings new code; an APB write to the code register here also replaces it.
// - lowest two pins are serial lines only in serial mode; strobe parallel only.
// - 7-bit slave address: six fixed bits, lsb from address-select pin.
// - device is write-only slave receiver; master sends read/write bit low.
// - serial code bytes use the same code table as parallel codes.
// - reset forces standby with oscillator stopped.
// - codes x0000 no tone oscillator on; x0001..x0011 standby oscillator off.
// - codes 08..0B low group, 0C..0F high group single tones.
// - codes 10..1F give the sixteen keypad tone pairs.
// - codes 24..29 give V.23, Bell 202 and V.21 modem tones.
// - table loads both dividers for pairs, one divider for single tones.
// - each divider divides the timebase into a square wave at the tone.
// - ratios give tabulated frequencies from a 3.579545 MHz timebase.
// - upper code inputs and strobe read low when left open.
// - data fall with clock high is start; data rise with clock high is stop.
// - device pulls data low during acknowledge clock after each byte.
// - codes 30..3F plus reused lower codes give two octaves of semitones.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "tci_map.vh"

module tci_tone_ctrl (
  input  wire                    clk,
  input  wire                    rst_n,
  input  wire                    mode_sel_pin,
  input  wire                    code_bit_0_or_serial_clock,
  input  wire                    code_bit_1_or_serial_data,
  input  wire                    code_bit_2,
  input  wire                    code_bit_3,
  input  wire                    app_select_lo,
  input  wire                    app_select_hi,
  input  wire                    strobe,
  input  wire                    address_select_pin,
  output reg                     serial_data_out,
  output reg                     serial_data_oe,
  output reg                     xtal_out,
  output reg                     osc_running,
  output reg                     tone_enable,
  output reg                     tone_low_sq,
  output reg                     tone_high_sq,
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`TCI_PADDR_W-1:0] paddr,
  input  wire [31:0]             pwdata,
  output reg  [31:0]             prdata,
  output reg                     pready,
  output reg                     pslverr
);

  // ****************************************************************
  // states of the serial slave
  // ****************************************************************
  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_ACK  = 3'd2;
  localparam S_DATA = 3'd3;
  localparam S_IGN  = 3'd4;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // bit order: {a0, mode, strobe, hi, lo, d3, d2, d1, d0}
  reg  [8:0] pin_s1_q;
  reg  [8:0] pin_s2_q;
  reg        strobe_prev_q;
  reg        scl_prev_q;
  reg        sda_prev_q;

  always @(posedge clk) begin
    if (!rst_n) begin
      // strobe and upper pins idle low, serial lines idle high: no false edge
      pin_s1_q      <= 9'h003;
      pin_s2_q      <= 9'h003;
      strobe_prev_q <= 1'b0;
      scl_prev_q    <= 1'b1;
      sda_prev_q    <= 1'b1;
    end else begin
      pin_s1_q      <= {address_select_pin, mode_sel_pin, strobe,
                        app_select_hi, app_select_lo, code_bit_3,
                        code_bit_2, code_bit_1_or_serial_data,
                        code_bit_0_or_serial_clock};
      pin_s2_q      <= pin_s1_q;
      strobe_prev_q <= pin_s2_q[6];
      scl_prev_q    <= pin_s2_q[0];
      sda_prev_q    <= pin_s2_q[1];
    end
  end

  wire       par_mode = pin_s2_q[7];
  wire       addr_lsb = pin_s2_q[8];
  wire [5:0] par_code = pin_s2_q[5:0];
  wire       scl      = pin_s2_q[0];
  wire       sda      = pin_s2_q[1];

  // strobe falling edge loads a parallel code only in parallel mode
  wire par_load = par_mode & strobe_prev_q & ~pin_s2_q[6];

  // ****************************************************************
  // serial slave receiver
  // ****************************************************************
  wire scl_rise = ~par_mode & scl & ~scl_prev_q;
  wire scl_fall = ~par_mode & ~scl & scl_prev_q;
  wire bus_start = ~par_mode & scl & scl_prev_q & sda_prev_q & ~sda;
  wire bus_stop  = ~par_mode & scl & scl_prev_q & ~sda_prev_q & sda;

  reg  [2:0] ser_st_q;
  reg  [7:0] shift_q;
  reg  [3:0] bit_cnt_q;
  reg        addressed_q;

  wire       byte_done = scl_fall & (bit_cnt_q == 4'd8);
  wire [6:0] own_addr  = {`TCI_SLAVE_HI6, addr_lsb};
  wire       ser_load  = (ser_st_q == S_DATA) & byte_done;

  always @(posedge clk) begin
    if (!rst_n) begin
      ser_st_q       <= S_IDLE;
      shift_q        <= 8'h00;
      bit_cnt_q      <= 4'd0;
      addressed_q    <= 1'b0;
      serial_data_oe <= 1'b0;
    end else if (par_mode) begin
      ser_st_q       <= S_IDLE;
      bit_cnt_q      <= 4'd0;
      addressed_q    <= 1'b0;
      serial_data_oe <= 1'b0;
    end else if (bus_start) begin
      ser_st_q       <= S_ADDR;
      bit_cnt_q      <= 4'd0;
      addressed_q    <= 1'b0;
      serial_data_oe <= 1'b0;
    end else if (bus_stop) begin
      ser_st_q       <= S_IDLE;
      addressed_q    <= 1'b0;
      serial_data_oe <= 1'b0;
    end else begin
      case (ser_st_q)
        S_ADDR, S_DATA: begin
          if (scl_rise && bit_cnt_q != 4'd8) begin
            shift_q   <= {shift_q[6:0], sda};
            bit_cnt_q <= bit_cnt_q + 4'd1;
          end else if (byte_done) begin
            if (ser_st_q == S_DATA) begin
              serial_data_oe <= 1'b1;
              ser_st_q       <= S_ACK;
            end else if (shift_q[7:1] == own_addr && !shift_q[0]) begin
              addressed_q    <= 1'b1;
              serial_data_oe <= 1'b1;
              ser_st_q       <= S_ACK;
            end else begin
              ser_st_q <= S_IGN;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            serial_data_oe <= 1'b0;
            bit_cnt_q      <= 4'd0;
            ser_st_q       <= S_DATA;
          end
        end
        S_IGN: begin
          serial_data_oe <= 1'b0;
        end
        default: begin
          serial_data_oe <= 1'b0;
        end
      endcase
    end
  end

  // the device only ever pulls the data line low
  always @(posedge clk) begin
    serial_data_out <= 1'b0;
  end

  // ****************************************************************
  // apb slave
  // ****************************************************************
  function reg_hit;
    input [`TCI_PADDR_W-1:0] a;
    begin
      reg_hit = (a == `TCI_REG_STATUS) || (a == `TCI_REG_CODE);
    end
  endfunction

  reg  [5:0]  code_q;
  wire [27:0] rom_q;
  wire [1:0]  kind = rom_q[27:26];

  wire apb_acc  = psel & penable & ~pready;
  wire apb_done = psel & penable & pready;
  wire wr_code  = apb_done & pwrite & (paddr == `TCI_REG_CODE);

  reg [31:0] rd_val;

  always @* begin
    rd_val = 32'h0000_0000;
    if (paddr == `TCI_REG_STATUS) begin
      rd_val[`TCI_ST_CODE_LSB +: 6] = code_q;
      rd_val[`TCI_ST_KIND_LSB +: 2] = kind;
      rd_val[`TCI_ST_OSC_BIT]       = osc_running;
      rd_val[`TCI_ST_PAR_BIT]       = par_mode;
      rd_val[`TCI_ST_BUSY_BIT]      = (ser_st_q != S_IDLE);
      rd_val[`TCI_ST_SEL_BIT]       = addressed_q;
    end else if (paddr == `TCI_REG_CODE) begin
      rd_val[5:0] = code_q;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_acc;
      if (apb_acc) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr <= ~reg_hit(paddr);
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // code register
  // ****************************************************************
  always @(posedge clk) begin
    if (!rst_n) begin
      code_q <= `TCI_CODE_RESET;
    end else if (wr_code) begin
      code_q <= pwdata[5:0];
    end else if (ser_load) begin
      code_q <= shift_q[5:0];
    end else if (par_load) begin
      code_q <= par_code;
    end
  end

  // ****************************************************************
  // decode table
  // ****************************************************************
  tci_div_rom u_rom (
    .clk    (clk),
    .rst_n  (rst_n),
    .addr   (code_q),
    .data_q (rom_q)
  );

  wire osc_on = (kind != `TCI_KIND_STBY);
  wire tone_on = (kind == `TCI_KIND_SINGLE) || (kind == `TCI_KIND_DUAL);

  // ****************************************************************
  // oscillator timebase
  // ****************************************************************
  reg  [27:0] acc_q;
  reg         tick_q;
  wire [27:0] acc_sum = acc_q + `TCI_OSC_HZ;

  always @(posedge clk) begin
    if (!rst_n) begin
      acc_q    <= 28'h000_0000;
      tick_q   <= 1'b0;
      xtal_out <= 1'b0;
    end else if (!osc_on) begin
      acc_q    <= 28'h000_0000;
      tick_q   <= 1'b0;
      xtal_out <= 1'b0;
    end else if (acc_sum >= `TCI_CLK_HZ) begin
      acc_q    <= acc_sum - `TCI_CLK_HZ;
      tick_q   <= 1'b1;
      xtal_out <= ~xtal_out;
    end else begin
      acc_q  <= acc_sum;
      tick_q <= 1'b0;
    end
  end

  // ****************************************************************
  // frequency dividers
  // ****************************************************************
  wire [12:0] ratio_a = tone_on ? rom_q[25:13] : 13'h0000;
  wire [12:0] ratio_b = (kind == `TCI_KIND_DUAL) ? rom_q[12:0] : 13'h0000;
  wire        sq_a;
  wire        sq_b;

  tci_freq_div #(.W(`TCI_RATIO_W)) u_div_a (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick_q),
    .ratio (ratio_a),
    .sq_q  (sq_a)
  );

  tci_freq_div #(.W(`TCI_RATIO_W)) u_div_b (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick_q),
    .ratio (ratio_b),
    .sq_q  (sq_b)
  );

  // ****************************************************************
  // output stage
  // ****************************************************************
  always @(posedge clk) begin
    if (!rst_n) begin
      osc_running  <= 1'b0;
      tone_enable  <= 1'b0;
      tone_low_sq  <= 1'b0;
      tone_high_sq <= 1'b0;
    end else begin
      osc_running  <= osc_on;
      tone_enable  <= tone_on;
      tone_low_sq  <= sq_a;
      tone_high_sq <= sq_b;
    end
  end

endmodule // tci_tone_ctrl

/* tb/tci_far_end.sv */
// far-end model: controller driving the code pins and the serial bus
`timescale 1ns/100ps

module tci_far_end (
  input  wire       clk,
  input  wire       sda_line,
  output reg  [5:0] pins,
  output reg        strobe,
  output reg        mode
);
  // ****
  // pin and bus tasks
  // ****
  initial begin
    pins = 6'h03; // serial-capable pins always driven
    strobe = 1'b0;
    mode = 1'b1;
  end

  task hold(input integer n);
    repeat (n) @(posedge clk);
  endtask

  task set_pins(input [5:0] c);
    begin
      @(posedge clk);
      pins <= c;
    end
  endtask

  task put_par(input [5:0] c);
    begin
      set_pins(c);
      hold(5); // code stable before strobe rise, held past fall
      strobe <= 1'b1;
      hold(5);
      strobe <= 1'b0;
      hold(8);
    end
  endtask

  // clock low 500, high 500 cycles: 100 kHz
  task sbit(input b);
    begin
      pins[1] <= b;
      hold(250);
      pins[0] <= 1'b1;
      hold(500);
      pins[0] <= 1'b0;
      hold(250);
    end
  endtask

  task start;
    begin
      pins[1] <= 1'b0; // data falls, clock high
      hold(500);
      pins[0] <= 1'b0;
      hold(250);
    end
  endtask

  task stop;
    begin
      pins[1] <= 1'b0;
      hold(250);
      pins[0] <= 1'b1;
      hold(500);
      pins[1] <= 1'b1; // data rises, clock high
      hold(500);
    end
  endtask

  task send(input [7:0] v, output logic ack);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        sbit(v[i]);
      pins[1] <= 1'b1;
      hold(250);
      pins[0] <= 1'b1;
      hold(250);
      ack = ~sda_line;
      hold(250);
      pins[0] <= 1'b0;
      hold(250);
    end
  endtask
endmodule // tci_far_end

/* tb/tci_tone_ctrl_bench.sv */
// testbench for the tone code input control block
`timescale 1ns/100ps
`include "tci_map.vh"

module tci_tone_ctrl_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [5:0]  pins;
  wire         strobe;
  wire         mode;
  wire         serial_data_out;
  wire         serial_data_oe;
  wire         xtal_out;
  wire         tone_enable;
  wire         osc;
  wire         lo_sq;
  wire         hi_sq;
  logic        a0_pin = 1'b1;
  wire         sda_line = pins[1] & ~(serial_data_oe & ~serial_data_out);
  integer      miscompares = 0;
  integer      checks = 0;
  integer      cycles = 0;
  integer      i;
  integer      n;
  logic        ack;
  logic        er;
  logic        xp;
  logic [31:0] d;
  logic [5:0]  codes [0:18] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h08, 6'h0B, 6'h0C, 6'h0F,
    6'h10, 6'h15, 6'h1F, 6'h20, 6'h23, 6'h24, 6'h29, 6'h2C, 6'h30, 6'h3F, 6'h0E};

  always #5 clk = ~clk;

  tci_far_end fe_u (
    .clk(clk),
    .sda_line(sda_line),
    .pins(pins),
    .strobe(strobe),
    .mode(mode)
  );

  tci_tone_ctrl dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .mode_sel_pin(mode),
    .code_bit_0_or_serial_clock(pins[0]),
    .code_bit_1_or_serial_data(sda_line),
    .code_bit_2(pins[2]),
    .code_bit_3(pins[3]),
    .app_select_lo(pins[4]),
    .app_select_hi(pins[5]),
    .strobe(strobe),
    .address_select_pin(a0_pin), // strap fixed outside reset
    .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe),
    .xtal_out(xtal_out),
    .osc_running(osc),
    .tone_enable(tone_enable),
    .tone_low_sq(lo_sq),
    .tone_high_sq(hi_sq),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  // ****
  // tasks
  // ****
  task complete_run;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd, output logic err);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
        @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  function [31:0] st_exp(input [5:0] c);
    reg [1:0] k;
    begin
      if (c[5:4] == 2'b01)
        k = `TCI_KIND_DUAL;
      else if (!c[4] && c[3:0] == 4'h0)
        k = `TCI_KIND_MUTE;
      else if (!c[4] && c[3:2] == 2'b00)
        k = `TCI_KIND_STBY;
      else
        k = `TCI_KIND_SINGLE;
      st_exp = {23'h0, k != `TCI_KIND_STBY, k, c};
    end
  endfunction

  task st_is(input [5:0] c);
    logic [31:0] x;
    logic [31:0] y;
    logic        t;
    begin
      x = st_exp(c);
      t = (x[7:6] == `TCI_KIND_SINGLE) || (x[7:6] == `TCI_KIND_DUAL);
      y = {29'h0, x[8], t, x[7:6] == `TCI_KIND_DUAL};
      apb(1'b0, `TCI_REG_STATUS, 32'h0, d, er);
      check({31'h0, er}, 32'h0);
      check(d, x | ({31'h0, mode} << `TCI_ST_PAR_BIT));
      check({31'h0, tone_enable}, {31'h0, t});
      repeat (40) @(posedge clk);
      check({29'h0, osc, lo_sq, hi_sq}, y);
    end
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      miscompares = miscompares + 1;
      complete_run;
    end
  end

  // ****
  // stimulus
  // ****
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    st_is(6'h01);
    apb(1'b0, 8'h08, 32'h0, d, er);
    check({31'h0, er}, 32'h1);
    check(d, 32'h0);
    apb(1'b1, `TCI_REG_STATUS, 32'h0000_003F, d, er);
    st_is(6'h01);
    for (i = 0; i < 19; i = i + 1) begin
      fe_u.put_par(codes[i]);
      st_is(codes[i]);
    end
    fe_u.set_pins(6'h13);
    fe_u.hold(10);
    st_is(6'h0E);
    n = 0;
    xp = xtal_out;
    repeat (2794) begin
      @(posedge clk);
      if (xtal_out !== xp)
        n = n + 1;
      xp = xtal_out;
    end
    check({31'h0, n >= 99 && n <= 101}, 32'h1);
    fe_u.mode <= 1'b0;
    fe_u.put_par(6'h13);
    st_is(6'h0E);
    fe_u.start;
    fe_u.send({`TCI_SLAVE_HI6, 1'b1, 1'b0}, ack); // write bit low
    check({31'h0, ack}, 32'h1);
    fe_u.send(8'hD1, ack);
    check({31'h0, ack}, 32'h1);
    fe_u.stop;
    st_is(6'h11);
    fe_u.start;
    fe_u.send({`TCI_SLAVE_HI6, 1'b0, 1'b0}, ack);
    check({31'h0, ack}, 32'h0);
    fe_u.send(8'h08, ack);
    check({31'h0, ack}, 32'h0);
    fe_u.stop;
    st_is(6'h11);
    fe_u.start;
    fe_u.send({`TCI_SLAVE_HI6, 1'b1, 1'b1}, ack);
    check({31'h0, ack}, 32'h0);
    fe_u.stop;
    apb(1'b1, `TCI_REG_CODE, 32'h0000_FF0C, d, er);
    apb(1'b0, `TCI_REG_CODE, 32'h0, d, er);
    check(d, 32'h0000_000C);
    st_is(6'h0C);
    rst_n <= 1'b0;
    a0_pin <= 1'b0; // strap changes only under reset
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    st_is(6'h01);
    fe_u.start;
    fe_u.send({`TCI_SLAVE_HI6, 1'b0, 1'b0}, ack);
    check({31'h0, ack}, 32'h1);
    fe_u.stop;
    complete_run;
  end
endmodule // tci_tone_ctrl_bench

/* tb/tci_tone_ctrl_properties.sv */
// checker: assertions on the tone code input control ports
`timescale 1ns/100ps

module tci_tone_ctrl_checker (
  input wire clk,
  input wire rst_n,
  input wire mode_sel_pin,
  input wire strobe,
  input wire psel,
  input wire penable,
  input wire serial_data_out,
  input wire serial_data_oe,
  input wire xtal_out,
  input wire osc_running,
  input wire tone_enable,
  input wire tone_low_sq,
  input wire tone_high_sq,
  input wire pready,
  input wire pslverr
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_reset_quiet;
    disable iff (1'b0) !rst_n |=> !osc_running && !tone_enable && !serial_data_oe && !xtal_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("output active after reset");

  property p_ack_low;
    serial_data_oe |-> !serial_data_out;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("data line driven high");

  property p_par_no_ack;
    mode_sel_pin [*6] |-> !serial_data_oe;
  endproperty
  a_par_no_ack: assert property (p_par_no_ack) else $error("serial ack in parallel mode");

  property p_hold_sel;
    (mode_sel_pin && !strobe && !psel) [*8] |-> $stable(osc_running) && $stable(tone_enable);
  endproperty
  a_hold_sel: assert property (p_hold_sel) else $error("selection changed without strobe");

  property p_tone_osc;
    tone_enable |-> osc_running;
  endproperty
  a_tone_osc: assert property (p_tone_osc) else $error("tone with oscillator off");

  property p_xtal_stop;
    !osc_running [*3] |-> !xtal_out;
  endproperty
  a_xtal_stop: assert property (p_xtal_stop) else $error("timebase runs in standby");

  property p_quiet_div;
    !tone_enable [*3] |-> !tone_low_sq && !tone_high_sq;
  endproperty
  a_quiet_div: assert property (p_quiet_div) else $error("divider runs without tone");

  property p_ready_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("no ready after one wait");

  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than a cycle");

  property p_err_ready;
    pslverr |-> pready && psel && penable;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error outside completion");
endmodule // tci_tone_ctrl_checker

bind tci_tone_ctrl tci_tone_ctrl_checker chk_u (
  .clk(clk),
  .rst_n(rst_n),
  .mode_sel_pin(mode_sel_pin),
  .strobe(strobe),
  .psel(psel),
  .penable(penable),
  .serial_data_out(serial_data_out),
  .serial_data_oe(serial_data_oe),
  .xtal_out(xtal_out),
  .osc_running(osc_running),
  .tone_enable(tone_enable),
  .tone_low_sq(tone_low_sq),
  .tone_high_sq(tone_high_sq),
  .pready(pready),
  .pslverr(pslverr)
);
